// >>> rtl/sysctl_hazard_timing.sv
// timing model of the system control coprocessor inside the core pipeline
// assumes a same-clock issue source, event pulses and a plain register port
`default_nettype none

module sysctl_hazard_timing (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // issue request
  input wire logic req_valid,
  input wire hazard_pkg::op_t req_op,
  input wire logic req_jump,
  input wire logic req_dst_v,
  input wire logic [4:0] req_dst,
  input wire logic req_src_a_v,
  input wire logic [4:0] req_src_a,
  input wire logic req_src_b_v,
  input wire logic [4:0] req_src_b,
  input wire logic [3:0] req_sel,
  input wire logic [15:0] req_wdata,
  input wire logic [7:0] req_line,
  output logic issue_ready,
  // core events and interrupt lines
  input wire logic [hazard_pkg::EV_N-1:0] ev_in,
  input wire logic [7:0] irq_pending,
  // timing strobes and mode
  output logic [hazard_pkg::S_N-1:0] sample_strobe,
  output logic [hazard_pkg::C_N-1:0] commit_strobe,
  output logic fetch_uncached,
  output logic kernel_mode,
  output logic irq_request,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  // ==========================================================================
  // state
  typedef struct packed {
    hazard_pkg::slot_t [hazard_pkg::NUM_AGES-2:0] st;
    hazard_pkg::slot_t pend;
    logic pend_v;
    logic ready;
    logic [1:0] stall_cnt;
    logic [15:0] status;
    logic [2:0] k0c;
    logic fetch_uncached;
    logic kernel;
    logic irq_request;
    logic [hazard_pkg::S_N-1:0] smp;
    logic [hazard_pkg::C_N-1:0] cmt;
    logic check_en;
    logic [hazard_pkg::V_N-1:0] viol;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    st: {(hazard_pkg::NUM_AGES-1){hazard_pkg::SLOT_EMPTY}},
    pend: hazard_pkg::SLOT_EMPTY,
    ready: 1'b1,
    status: hazard_pkg::STATUS_RST,
    k0c: hazard_pkg::K0C_RST,
    fetch_uncached: 1'b1,
    kernel: 1'b1,
    check_en: 1'b1,
    default: '0
  };

  state_t r;
  state_t next_r;

  // ==========================================================================
  // issue and general register interlock
  hazard_pkg::slot_t req_slot;
  hazard_pkg::slot_t age [hazard_pkg::NUM_AGES];
  hazard_pkg::slot_t age0;
  logic take;
  logic dep;

  assign req_slot = '{
    op: req_op,
    ev: ev_in,
    jump: req_jump,
    dst_v: req_dst_v,
    dst: req_dst,
    sel: req_sel,
    wdata: req_wdata,
    line: req_line
  };

  assign take = req_valid && r.ready;

  // only general registers are compared; coprocessor state stalls only a jump right after a move that sets the fetch stall flag
  assign dep = take && r.st[0].dst_v && ((req_src_a_v && (req_src_a == r.st[0].dst))
               || (req_src_b_v && (req_src_b == r.st[0].dst)));

  // a dependent request waits one cycle in pend, leaving a bubble
  always_comb begin
    age0 = hazard_pkg::SLOT_EMPTY;
    if (r.pend_v) begin
      age0 = r.pend;
    end else if (take && !dep) begin
      age0 = req_slot;
    end
    age0.ev = ev_in;
  end

  // ==========================================================================
  // per-age decode taps
  logic [hazard_pkg::S_N-1:0] smp_acc [hazard_pkg::NUM_AGES+1];
  logic [hazard_pkg::C_N-1:0] cmt_acc [hazard_pkg::NUM_AGES+1];
  logic [hazard_pkg::S_N-1:0] smp_all;
  logic [hazard_pkg::C_N-1:0] cmt_all;

  assign smp_acc[0] = '0;
  assign cmt_acc[0] = '0;
  assign age[0] = age0;

  genvar g;
  generate
    for (g = 0; g < hazard_pkg::NUM_AGES; g++) begin : g_tap
      hazard_tap_if tap ();
      if (g > 0) begin : g_old
        assign age[g] = r.st[g-1];
      end
      assign tap.slot = age[g];
      // age g is strobed in hazard cycle g+2 via the output register
      hazard_decode #(
        .HC(g + 2)
      ) u_decode (
        .tap(tap.dec)
      );
      assign smp_acc[g+1] = smp_acc[g] | tap.smp;
      assign cmt_acc[g+1] = cmt_acc[g] | tap.cmt;
    end
  endgenerate

  assign smp_all = smp_acc[hazard_pkg::NUM_AGES];
  assign cmt_all = cmt_acc[hazard_pkg::NUM_AGES];

  // ==========================================================================
  // slots at the ages that change state
  hazard_pkg::slot_t move_slot;
  hazard_pkg::slot_t ret_slot;
  hazard_pkg::slot_t fetch_slot;
  logic cache_now;
  logic [2:0] store_hit;
  logic [2:0] busy_between;

  assign move_slot = age[hazard_pkg::MOVE_TO_DST-2];
  assign ret_slot = age[hazard_pkg::EXC_RETURN_DST-2];
  assign fetch_slot = age[hazard_pkg::UNCACHED_FETCH-2];

  assign cache_now = (age[0].op == hazard_pkg::OP_TAG_LOAD)
                     || (age[0].op == hazard_pkg::OP_TAG_STORE)
                     || (age[0].op == hazard_pkg::OP_CACHE_HIT);

  generate
    for (g = 1; g <= 3; g++) begin : g_store
      assign store_hit[g-1] = (age[g].op == hazard_pkg::OP_STORE)
                              && (age[g].line == age[0].line);
      assign busy_between[g-1] = (age[g].op == hazard_pkg::OP_LOAD)
                                 || (age[g].op == hazard_pkg::OP_TAG_LOAD)
                                 || (age[g].op == hazard_pkg::OP_TAG_STORE)
                                 || (age[g].op == hazard_pkg::OP_CACHE_HIT);
    end
  endgenerate

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;

    // pipeline advance and registered strobes
    next_r.st = {r.st[hazard_pkg::NUM_AGES-3:0], age[0]};
    next_r.smp = smp_all;
    next_r.cmt = cmt_all;

    // interlock hold
    next_r.pend_v = dep;
    if (dep) begin
      next_r.pend = req_slot;
    end

    // jump right after a move that sets the fetch stall flag
    if (r.stall_cnt != 2'h0) begin
      next_r.stall_cnt = r.stall_cnt - 2'h1;
    end
    if (age[0].jump && (age[1].op == hazard_pkg::OP_MOVE_TO)
        && (age[1].sel == hazard_pkg::SEL_STATUS)
        && age[1].wdata[hazard_pkg::ST_FSTALL]) begin
      next_r.stall_cnt = hazard_pkg::FETCH_STALL_SLOTS;
    end
    next_r.ready = !next_r.pend_v && (next_r.stall_cnt == 2'h0);

    // move to a coprocessor register lands in its commit cycle
    if (cmt_all[hazard_pkg::C_SYSREG]) begin
      case (move_slot.sel)
        hazard_pkg::SEL_STATUS: begin
          // mode, levels and enables change together in one step
          next_r.status = move_slot.wdata;
          next_r.status[hazard_pkg::ST_TS] = r.status[hazard_pkg::ST_TS];
        end
        hazard_pkg::SEL_CONFIG: begin
          next_r.k0c = move_slot.wdata[2:0];
        end
        default: begin
          next_r.k0c = r.k0c;
        end
      endcase
    end

    // exception return drops error level first, else exception level
    if (cmt_all[hazard_pkg::C_LEVEL] && (ret_slot.op == hazard_pkg::OP_EXC_RETURN)) begin
      if (r.status[hazard_pkg::ST_ERL]) begin
        next_r.status[hazard_pkg::ST_ERL] = 1'b0;
      end else begin
        next_r.status[hazard_pkg::ST_EXL] = 1'b0;
      end
    end

    // hardware sets win over a software write in the same cycle
    if (cmt_all[hazard_pkg::C_EXC_PC]) begin
      next_r.status[hazard_pkg::ST_EXL] = 1'b1;
    end
    if (cmt_all[hazard_pkg::C_SHUTDOWN]) begin
      next_r.status[hazard_pkg::ST_TS] = 1'b1;
    end

    // cache mode seen by fetch from the third instruction after the move
    if ((fetch_slot.op == hazard_pkg::OP_MOVE_TO)
        && (fetch_slot.sel == hazard_pkg::SEL_CONFIG)) begin
      next_r.fetch_uncached = (fetch_slot.wdata[2:0] == hazard_pkg::K0C_UNCACHED);
    end

    // committed mode; no guard against the five-instruction window
    next_r.kernel = (next_r.status[hazard_pkg::ST_KSU +: 2] == hazard_pkg::KSU_KERNEL)
                    || next_r.status[hazard_pkg::ST_EXL]
                    || next_r.status[hazard_pkg::ST_ERL];

    // interrupt recognition from the status seen at the sample cycle
    next_r.irq_request = smp_all[hazard_pkg::S_IRQ]
                         && (|(irq_pending & r.status[hazard_pkg::ST_IM +: 8]))
                         && r.status[hazard_pkg::ST_IE]
                         && !r.status[hazard_pkg::ST_EXL]
                         && !r.status[hazard_pkg::ST_ERL];

    // software clear of spacing faults, before new sets
    if (wr && (addr == hazard_pkg::REG_VIOL)) begin
      next_r.viol = r.viol & ~wdata[hazard_pkg::V_N-1:0];
    end
    if (wr && (addr == hazard_pkg::REG_CTRL)) begin
      next_r.check_en = wdata[0];
    end

    // spacing faults left to the instruction stream
    if (r.check_en) begin
      if ((age[0].op == hazard_pkg::OP_MOVE_FROM) && (age[1].op == hazard_pkg::OP_MOVE_TO)) begin
        next_r.viol[hazard_pkg::V_MOVE_PAIR] = 1'b1;
      end
      if (cache_now && (store_hit[0] || store_hit[1]
          || (store_hit[2] && (busy_between[0] || busy_between[1])))) begin
        next_r.viol[hazard_pkg::V_STORE_CACHE] = 1'b1;
      end
    end

    // read data stand for one cycle only
    next_r.rdata = '0;
    if (rd) begin
      case (addr)
        hazard_pkg::REG_STATUS: begin
          next_r.rdata[15:0] = r.status;
          next_r.rdata[hazard_pkg::CFG_K0C +: 3] = r.k0c;
        end
        hazard_pkg::REG_VIOL: begin
          next_r.rdata[hazard_pkg::V_N-1:0] = r.viol;
        end
        hazard_pkg::REG_CTRL: begin
          next_r.rdata[0] = r.check_en;
        end
        default: begin
          next_r.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r <= STATE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  assign issue_ready = r.ready;
  assign sample_strobe = r.smp;
  assign commit_strobe = r.cmt;
  assign fetch_uncached = r.fetch_uncached;
  assign kernel_mode = r.kernel;
  assign irq_request = r.irq_request;
  assign rdata = r.rdata;

endmodule

`default_nettype wire

// >>> rtl/hazard_pkg.sv
// shared figures for the coprocessor hazard timing block: op codes, hazard
// cycles, strobe and status bit positions, register offsets and slot layout
// assumes one core clock and one issue per cycle
`default_nettype none

package hazard_pkg;

  // ==========================================================================
  // issued operations
  typedef enum logic [13:0] {
    OP_NONE        = 14'h0001,
    OP_ALU         = 14'h0002,
    OP_MOVE_TO     = 14'h0004,
    OP_MOVE_FROM   = 14'h0008,
    OP_XLAT_READ   = 14'h0010,
    OP_XLAT_WR_IDX = 14'h0020,
    OP_XLAT_WR_RND = 14'h0040,
    OP_XLAT_PROBE  = 14'h0080,
    OP_EXC_RETURN  = 14'h0100,
    OP_TAG_LOAD    = 14'h0200,
    OP_TAG_STORE   = 14'h0400,
    OP_CACHE_HIT   = 14'h0800,
    OP_LOAD        = 14'h1000,
    OP_STORE       = 14'h2000
  } op_t;
  // jumps and branches travel as alu ops with a flag
  localparam int unsigned NUM_AGES = 5;

  // ==========================================================================
  // hazard cycles, counted from issue as cycle 1
  localparam int unsigned MOVE_TO_DST = 5;
  localparam int unsigned MOVE_FROM_SRC = 3;
  localparam int unsigned XLAT_SRC = 2;
  localparam int unsigned XLAT_READ_DST = 5;
  localparam int unsigned XLAT_WRITE_DST = 5;
  localparam int unsigned XLAT_PROBE_DST = 6;
  localparam int unsigned EXC_RETURN_SRC = 2;
  localparam int unsigned EXC_RETURN_DST = 4;
  localparam int unsigned TAG_LOAD_DST = 5;
  localparam int unsigned TAG_STORE_SRC = 3;
  localparam int unsigned CACHE_HIT_SRC = 3;
  localparam int unsigned CACHE_HIT_DST = 5;
  localparam int unsigned USABLE_SRC = 2;
  localparam int unsigned FETCH_SRC = 2;
  localparam int unsigned FETCH_EXC_PC_DST = 4;
  localparam int unsigned FETCH_EXC_INFO_DST = 5;
  localparam int unsigned IRQ_SRC = 2;
  localparam int unsigned LDST_SRC = 3;
  localparam int unsigned LDST_EXC_DST = 5;
  localparam int unsigned SHUTDOWN_INST_DST = 2;
  localparam int unsigned SHUTDOWN_DATA_DST = 4;
  localparam int unsigned UNCACHED_FETCH = 4;
  localparam logic [1:0] FETCH_STALL_SLOTS = 2'h3;

  // ==========================================================================
  // event inputs, sample strobes, commit strobes
  localparam int EV_FETCH_EXC = 0;
  localparam int EV_LDST_EXC = 1;
  localparam int EV_SHUT_INST = 2;
  localparam int EV_SHUT_DATA = 3;
  localparam int EV_IRQ = 4;
  localparam int EV_N = 5;
  localparam int S_SYSREG = 0;
  localparam int S_XLAT = 1;
  localparam int S_RET_PC = 2;
  localparam int S_TAG = 3;
  localparam int S_LINE = 4;
  localparam int S_USABLE = 5;
  localparam int S_FETCH = 6;
  localparam int S_IRQ = 7;
  localparam int S_LDST = 8;
  localparam int S_N = 9;
  localparam int C_SYSREG = 0;
  localparam int C_ENTRY = 1;
  localparam int C_XLAT = 2;
  localparam int C_INDEX = 3;
  localparam int C_LEVEL = 4;
  localparam int C_TAG = 5;
  localparam int C_LINE = 6;
  localparam int C_EXC_PC = 7;
  localparam int C_EXC_INFO = 8;
  localparam int C_SHUTDOWN = 9;
  localparam int C_N = 10;

  // ==========================================================================
  // status word layout and targets of a move
  localparam int ST_IE = 0;
  localparam int ST_EXL = 1;
  localparam int ST_ERL = 2;
  localparam int ST_KSU = 3;
  localparam int ST_FSTALL = 5;
  localparam int ST_TS = 6;
  localparam int ST_IM = 8;
  localparam int CFG_K0C = 16;
  localparam logic [1:0] KSU_KERNEL = 2'h0;
  localparam logic [2:0] K0C_UNCACHED = 3'h2;
  localparam logic [15:0] STATUS_RST = 16'h0004;
  localparam logic [2:0] K0C_RST = 3'h2;
  localparam logic [3:0] SEL_STATUS = 4'h0;
  localparam logic [3:0] SEL_CONFIG = 4'h1;

  // ==========================================================================
  // software view
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_VIOL = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam int V_MOVE_PAIR = 0;
  localparam int V_STORE_CACHE = 1;
  localparam int V_N = 2;

  typedef struct packed {
    op_t op;
    logic [EV_N-1:0] ev;
    logic jump;
    logic dst_v;
    logic [4:0] dst;
    logic [3:0] sel;
    logic [15:0] wdata;
    logic [7:0] line;
  } slot_t;

  localparam slot_t SLOT_EMPTY = '{op: OP_NONE, default: '0};

endpackage

`default_nettype wire

// >>> rtl/hazard_tap_if.sv
// one pipeline age tap: the slot at that age and the strobes it raises
// assumes hazard_pkg compiled first
`default_nettype none

interface hazard_tap_if;
  hazard_pkg::slot_t slot;
  logic [hazard_pkg::S_N-1:0] smp;
  logic [hazard_pkg::C_N-1:0] cmt;
  modport feed (output slot, input smp, input cmt);
  modport dec (input slot, output smp, output cmt);
endinterface

`default_nettype wire

// >>> rtl/hazard_decode.sv
// decodes which source samples and destination commits fall on one hazard cycle
// assumes the slot presented is the one issued HC-2 cycles earlier
`default_nettype none

module hazard_decode #(
  parameter int unsigned HC = 2
) (
  // tap of one pipeline age
  hazard_tap_if.dec tap
);

  hazard_pkg::op_t op;
  logic xlat_write;
  logic xlat_any;
  logic cache_any;
  logic cop_any;

  assign op = tap.slot.op;
  assign xlat_write = (op == hazard_pkg::OP_XLAT_WR_IDX) || (op == hazard_pkg::OP_XLAT_WR_RND);
  assign xlat_any = xlat_write || (op == hazard_pkg::OP_XLAT_READ)
                    || (op == hazard_pkg::OP_XLAT_PROBE);
  assign cache_any = (op == hazard_pkg::OP_TAG_LOAD) || (op == hazard_pkg::OP_TAG_STORE)
                     || (op == hazard_pkg::OP_CACHE_HIT);
  assign cop_any = xlat_any || cache_any || (op == hazard_pkg::OP_MOVE_TO)
                   || (op == hazard_pkg::OP_MOVE_FROM) || (op == hazard_pkg::OP_EXC_RETURN);

  // ==========================================================================
  // strobes for this hazard cycle
  always_comb begin
    tap.smp = '0;
    tap.cmt = '0;
    tap.smp[hazard_pkg::S_SYSREG] = (op == hazard_pkg::OP_MOVE_FROM)
                                    && (HC == hazard_pkg::MOVE_FROM_SRC);
    tap.smp[hazard_pkg::S_XLAT] = xlat_any && (HC == hazard_pkg::XLAT_SRC);
    tap.smp[hazard_pkg::S_RET_PC] = (op == hazard_pkg::OP_EXC_RETURN)
                                    && (HC == hazard_pkg::EXC_RETURN_SRC);
    tap.smp[hazard_pkg::S_TAG] = (op == hazard_pkg::OP_TAG_STORE)
                                 && (HC == hazard_pkg::TAG_STORE_SRC);
    tap.smp[hazard_pkg::S_LINE] = (op == hazard_pkg::OP_CACHE_HIT)
                                  && (HC == hazard_pkg::CACHE_HIT_SRC);
    tap.smp[hazard_pkg::S_USABLE] = cop_any && (HC == hazard_pkg::USABLE_SRC);
    tap.smp[hazard_pkg::S_FETCH] = (op != hazard_pkg::OP_NONE)
                                   && (HC == hazard_pkg::FETCH_SRC);
    tap.smp[hazard_pkg::S_IRQ] = tap.slot.ev[hazard_pkg::EV_IRQ]
                                 && (HC == hazard_pkg::IRQ_SRC);
    tap.smp[hazard_pkg::S_LDST] = ((op == hazard_pkg::OP_LOAD) || (op == hazard_pkg::OP_STORE))
                                  && (HC == hazard_pkg::LDST_SRC);
    tap.cmt[hazard_pkg::C_SYSREG] = (op == hazard_pkg::OP_MOVE_TO)
                                    && (HC == hazard_pkg::MOVE_TO_DST);
    tap.cmt[hazard_pkg::C_ENTRY] = (op == hazard_pkg::OP_XLAT_READ)
                                   && (HC == hazard_pkg::XLAT_READ_DST);
    tap.cmt[hazard_pkg::C_XLAT] = xlat_write && (HC == hazard_pkg::XLAT_WRITE_DST);
    tap.cmt[hazard_pkg::C_INDEX] = (op == hazard_pkg::OP_XLAT_PROBE)
                                   && (HC == hazard_pkg::XLAT_PROBE_DST);
    tap.cmt[hazard_pkg::C_LEVEL] = (op == hazard_pkg::OP_EXC_RETURN)
                                   && (HC == hazard_pkg::EXC_RETURN_DST);
    tap.cmt[hazard_pkg::C_TAG] = (op == hazard_pkg::OP_TAG_LOAD)
                                 && (HC == hazard_pkg::TAG_LOAD_DST);
    tap.cmt[hazard_pkg::C_LINE] = (op == hazard_pkg::OP_CACHE_HIT)
                                  && (HC == hazard_pkg::CACHE_HIT_DST);
    tap.cmt[hazard_pkg::C_EXC_PC] =
      (tap.slot.ev[hazard_pkg::EV_FETCH_EXC] && (HC == hazard_pkg::FETCH_EXC_PC_DST))
      || (tap.slot.ev[hazard_pkg::EV_LDST_EXC] && (HC == hazard_pkg::LDST_EXC_DST));
    tap.cmt[hazard_pkg::C_EXC_INFO] =
      (tap.slot.ev[hazard_pkg::EV_FETCH_EXC] && (HC == hazard_pkg::FETCH_EXC_INFO_DST))
      || (tap.slot.ev[hazard_pkg::EV_LDST_EXC] && (HC == hazard_pkg::LDST_EXC_DST));
    tap.cmt[hazard_pkg::C_SHUTDOWN] =
      (tap.slot.ev[hazard_pkg::EV_SHUT_INST] && (HC == hazard_pkg::SHUTDOWN_INST_DST))
      || (tap.slot.ev[hazard_pkg::EV_SHUT_DATA] && (HC == hazard_pkg::SHUTDOWN_DATA_DST));
  end

endmodule

`default_nettype wire

// >>> verif/sysctl_hazard_checker.sv
// concurrent checks of hazard cycle timing seen at the block's top ports
// assumes hazard_pkg is compiled first and a single core clock
`default_nettype none

module sysctl_hazard_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // issue side
  input wire logic req_valid,
  input wire hazard_pkg::op_t req_op,
  input wire logic req_jump,
  input wire logic req_dst_v,
  input wire logic [4:0] req_dst,
  input wire logic req_src_a_v,
  input wire logic [4:0] req_src_a,
  input wire logic [3:0] req_sel,
  input wire logic [15:0] req_wdata,
  input wire logic issue_ready,
  input wire logic [4:0] ev_in,
  // timing outputs
  input wire logic [8:0] sample_strobe,
  input wire logic [9:0] commit_strobe,
  input wire logic fetch_uncached
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic tk, mt, pd_v;
  logic [4:0] pd;
  wire [8:0] s = sample_strobe;
  wire [9:0] c = commit_strobe;
  assign tk = req_valid && issue_ready;
  assign mt = tk && req_op == hazard_pkg::OP_MOVE_TO;
  function automatic logic is(hazard_pkg::op_t o);
    return tk && req_op == o;
  endfunction
  // destination of the instruction taken one cycle before
  always_ff @(posedge sys_clk) begin
    pd_v <= nrst && tk && req_dst_v;
    pd <= req_dst;
  end

  // ==========================================================================
  // assertions
  a_move_to_write: assert property (mt |-> ##1 s[5] && s[6] ##3 c[0])
    else $error("move to timing wrong");
  a_move_from_read: assert property (is(hazard_pkg::OP_MOVE_FROM) |-> ##2 s[0])
    else $error("move from sample wrong");
  a_xlat_read_timing: assert property (is(hazard_pkg::OP_XLAT_READ) |-> ##1 s[1] ##3 c[1])
    else $error("entry read timing wrong");
  a_probe_index: assert property (is(hazard_pkg::OP_XLAT_PROBE) |-> ##1 s[1] ##4 c[3])
    else $error("probe timing wrong");
  a_return_levels: assert property (is(hazard_pkg::OP_EXC_RETURN) |-> ##1 s[2] ##2 c[4])
    else $error("return timing wrong");
  a_hit_line: assert property (is(hazard_pkg::OP_CACHE_HIT) |-> ##2 s[4] ##2 c[6])
    else $error("hit op timing wrong");
  a_fetch_exc_write: assert property (ev_in[0] |-> ##3 c[7] ##1 c[8])
    else $error("fetch exception timing wrong");
  a_irq_sample: assert property (ev_in[4] |-> ##1 s[7])
    else $error("interrupt sample wrong");
  a_gpr_stall: assert property (tk && pd_v && req_src_a_v && req_src_a == pd |=> !issue_ready)
    else $error("no stall on register use");
  a_no_cop_stall: assert property (mt |=> issue_ready)
    else $error("stall on coprocessor op");
  a_uncached_third: assert property (mt && req_sel == hazard_pkg::SEL_CONFIG |-> ##3
    fetch_uncached == ($past(req_wdata[2:0], 3) == hazard_pkg::K0C_UNCACHED))
    else $error("uncached switch wrong");
  a_jump_stall: assert property ($past(mt && req_sel == 4'h0 && req_wdata[5])
    && tk && req_jump |=> !issue_ready [*3])
    else $error("jump stall wrong");
  c_move_to: cover property (mt);
  c_jump: cover property (tk && req_jump);
  c_fetch_exc: cover property (ev_in[0]);
endmodule

bind sysctl_hazard_timing sysctl_hazard_chk i_chk (.*);

`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the hazard timing block through its ports
// assumes package, design and checker files are compiled first
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_jump = 1'b0;
  logic req_dst_v = 1'b0, req_src_a_v = 1'b0, wr = 1'b0, rd = 1'b0;
  logic issue_ready, fetch_uncached, kernel_mode, irq_request;
  hazard_pkg::op_t req_op = hazard_pkg::OP_NONE;
  logic [4:0] req_dst = 5'h0, req_src_a = 5'h0, ev_in = 5'h0;
  logic req_src_b_v = 1'b0;
  logic [4:0] req_src_b = 5'h0;
  logic [3:0] req_sel = 4'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [7:0] req_line = 8'h0, irq_pending = 8'h0, addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [8:0] sample_strobe;
  logic [9:0] commit_strobe;
  int n_fail = 0, total_checks = 0, cycles = 0;
  hazard_pkg::op_t seq[9] = '{hazard_pkg::OP_XLAT_READ, hazard_pkg::OP_XLAT_WR_IDX,
    hazard_pkg::OP_XLAT_WR_RND, hazard_pkg::OP_XLAT_PROBE, hazard_pkg::OP_EXC_RETURN,
    hazard_pkg::OP_TAG_LOAD, hazard_pkg::OP_CACHE_HIT, hazard_pkg::OP_LOAD,
    hazard_pkg::OP_STORE};

  sysctl_hazard_timing i_dut (.*);

  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      conclude();
    end
  end

  // ==========================================================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic op1(input hazard_pkg::op_t o, input logic [3:0] s, input logic [15:0] d);
    req_valid <= 1'b1;
    req_op <= o;
    req_sel <= s;
    req_wdata <= d;
    req_line <= 8'h05;
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    req_valid <= 1'b0;
    req_jump <= 1'b0;
    req_src_a_v <= 1'b0;
    ev_in <= 5'h0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
    @(posedge sys_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd_reg(hazard_pkg::REG_STATUS, 32'h00020004);
    rd_reg(hazard_pkg::REG_CTRL, 32'h1);
    rd_reg(8'h0c, 32'h0);
    foreach (seq[i]) op1(seq[i], 4'h0, 16'h0);
    idle(8);
    rd_reg(hazard_pkg::REG_STATUS, 32'h00020000);
    for (int g = 0; g < 3; g += 2) begin
      op1(hazard_pkg::OP_MOVE_TO, hazard_pkg::SEL_STATUS, 16'hff01);
      repeat (g) op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
      op1(hazard_pkg::OP_MOVE_FROM, 4'h0, 16'h0);
      op1(hazard_pkg::OP_STORE, 4'h0, 16'h0);
      repeat (g) op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
      op1(hazard_pkg::OP_CACHE_HIT, 4'h0, 16'h0);
      idle(6);
      rd_reg(hazard_pkg::REG_VIOL, g ? 32'h0 : 32'h3);
      wr_reg(hazard_pkg::REG_VIOL, 32'h3);
    end
    rd_reg(hazard_pkg::REG_STATUS, 32'h0002ff01);
    irq_pending <= 8'h01;
    for (int i = 4; i >= 0; i--) begin
      ev_in <= 5'(1 << i);
      @(posedge sys_clk);
      #1 check(irq_request, i == 4);
      idle(6);
    end
    rd_reg(hazard_pkg::REG_STATUS, 32'h0002ff43);
    op1(hazard_pkg::OP_MOVE_TO, hazard_pkg::SEL_CONFIG, 16'h0000);
    idle(5);
    #1 check(fetch_uncached, 1'b0);
    op1(hazard_pkg::OP_MOVE_TO, hazard_pkg::SEL_CONFIG, 16'h0002);
    idle(1);
    #1 check(fetch_uncached, 1'b0);
    @(posedge sys_clk);
    #1 check(fetch_uncached, 1'b1);
    req_dst_v <= 1'b1;
    req_dst <= 5'h03;
    op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
    req_src_a_v <= 1'b1;
    req_src_a <= 5'h03;
    op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
    #1 check(issue_ready, 1'b0);
    req_dst_v <= 1'b0;
    idle(3);
    // second source port against the same producer
    req_dst_v <= 1'b1;
    op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
    req_src_b_v <= 1'b1;
    req_src_b <= 5'h03;
    op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
    #1 check(issue_ready, 1'b0);
    req_dst_v <= 1'b0;
    req_src_b_v <= 1'b0;
    idle(3);
    op1(hazard_pkg::OP_MOVE_TO, hazard_pkg::SEL_STATUS, 16'h0030);
    req_jump <= 1'b1;
    op1(hazard_pkg::OP_ALU, 4'h0, 16'h0);
    #1 check(issue_ready, 1'b0);
    idle(4);
    #1 check(kernel_mode, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
